// File: logic/brt_regbank.sv
`timescale 1ns/1ps
// Operation
// - The five control registers sit at consecutive bus addresses 0x35 to 0x39.
// - Register 0x35 holds a writable 6-bit normal set-point in bits 5:0, reset zero.
// - Bit 6 of 0x35 is the read-only range bit, loaded only at configuration time.
// - Register 0x36 holds a writable 6-bit standby set-point in bits 5:0, reset zero.
// - Bit 6 of 0x36 and 0x37 is read-only and mirrors the configured range bit.
// - Register 0x37 holds a writable 6-bit sleep set-point in bits 5:0, reset zero.
// - Bit 7 of all three set-point registers is unused and reads zero.
// - Register 0x38 bits 3:0 are the writable switching mode passed to the regulator.
// - Bit 5 of 0x38 picks sleep behaviour, 0 off and 1 pulse-frequency, reset zero.
// - Bits 4, 6 and 7 of 0x38 are unused and read zero.
// - Bit 0 of 0x39 selects current limit, 0 high and 1 low, reset zero.
// - Bits 3:2 of 0x39 are the writable switching frequency selector, reset zero.
// - Bits 5:4 of 0x39 are the writable phase clock selector, reset zero.
// - Bits 7:6 of 0x39 are the writable voltage slew speed selector, reset zero.
module brt_regbank
    import brt_pkg::*;
(
    input  wire logic          core_clk,   // Logic clock, 40 MHz
    input  wire logic          reset,      // Async reset, active high
    input  wire brt_req_s      req,        // Register access from the serial slave
    output logic        [7:0]  rdData,     // Read byte, registered
    output logic               rdValid,    // Read data valid pulse
    input  wire logic          cfgLoad,    // Configuration load strobe
    input  wire logic          cfgRange,   // Range bit from fuse or trial config
    input  wire brt_op_state_e opState,    // Current operating state
    output brt_ctrl_s          ctrl        // Controls to the regulator
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [BRT_NUM_REGS-1:0] wrSel;
    logic [7:0]              regVal [BRT_NUM_REGS];
    logic [7:0]              normalV;
    logic [7:0]              standbyV;
    logic [7:0]              sleepV;
    logic [7:0]              modeV;
    logic [7:0]              configV;
    logic                    inMap;
    logic [2:0]              regIdx;

    assign inMap  = (req.addr >= BRT_ADDR_FIRST) && (req.addr <= BRT_ADDR_LAST);
    assign regIdx = 3'(req.addr - BRT_ADDR_FIRST);

    localparam logic [7:0] WMASKS [BRT_NUM_REGS] = '{BRT_SETPT_WMASK, BRT_SETPT_WMASK,
                                                    BRT_SETPT_WMASK, BRT_MODE_WMASK,
                                                    BRT_CONFIG_WMASK};

    // ------------------------------------------------------------
    // Writable storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BRT_NUM_REGS; gi++) begin : gReg
            assign wrSel[gi] = req.write && inMap && (regIdx == 3'(gi));
            brt_reg_cell #(
                .WMASK (WMASKS[gi])
            ) uCell (
                .core_clk (core_clk),
                .reset    (reset),
                .wrEn     (wrSel[gi]),
                .wrData   (req.wdata),
                .value    (regVal[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Range bit, loaded only by configuration
    // ------------------------------------------------------------
    logic rangeBit_q;
    logic rangeBit_d;

    // Host writes never reach this bit
    assign rangeBit_d = cfgLoad ? cfgRange : rangeBit_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rangeBit_q <= BRT_RESET_VAL[BRT_RANGE_BIT];
        end else begin
            rangeBit_q <= rangeBit_d;
        end
    end

    // ------------------------------------------------------------
    // Read-back images
    // ------------------------------------------------------------
    assign normalV  = {1'b0, rangeBit_q, regVal[0][BRT_SETPT_W-1:0]};
    assign standbyV = {1'b0, rangeBit_q, regVal[1][BRT_SETPT_W-1:0]};
    assign sleepV   = {1'b0, rangeBit_q, regVal[2][BRT_SETPT_W-1:0]};
    assign modeV    = regVal[3] & BRT_MODE_WMASK;
    assign configV  = regVal[4];

    logic [7:0] rdMux;
    assign rdMux = !inMap                     ? BRT_ZERO_BYTE :
                   (req.addr == BRT_ADDR_NORMAL)  ? normalV  :
                   (req.addr == BRT_ADDR_STANDBY) ? standbyV :
                   (req.addr == BRT_ADDR_SLEEP)   ? sleepV   :
                   (req.addr == BRT_ADDR_MODE)    ? modeV    : configV;

    logic [7:0] rdData_q;
    logic       rdValid_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdData_q  <= BRT_ZERO_BYTE;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= req.read;
            if (req.read) begin
                rdData_q <= rdMux;
            end
        end
    end

    assign rdData  = rdData_q;
    assign rdValid = rdValid_q;

    // ------------------------------------------------------------
    // Regulator controls
    // ------------------------------------------------------------
    logic [7:0] activeV;
    // Host is trusted to keep codes under 64 for sub-2 V outputs; no clamp here
    assign activeV = (opState == BRT_OP_STANDBY) ? standbyV :
                     (opState == BRT_OP_SLEEP)   ? sleepV   : normalV;

    brt_ctrl_s ctrl_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q.voltageCode     <= activeV[BRT_RANGE_BIT:0];
            ctrl_q.switchingMode   <= modeV[3:0];
            ctrl_q.sleepPfm        <= modeV[5];
            ctrl_q.currentLimitLow <= configV[0];
            ctrl_q.frequencySel    <= configV[3:2];
            ctrl_q.phaseSel        <= configV[5:4];
            ctrl_q.slewSpeedSel    <= configV[7:6];
        end
    end

    assign ctrl = ctrl_q;
endmodule : brt_regbank

// File: logic/brt_pkg.sv
package brt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] BRT_ADDR_NORMAL  = 8'h35;
    localparam logic [7:0] BRT_ADDR_STANDBY = 8'h36;
    localparam logic [7:0] BRT_ADDR_SLEEP   = 8'h37;
    localparam logic [7:0] BRT_ADDR_MODE    = 8'h38;
    localparam logic [7:0] BRT_ADDR_CONFIG  = 8'h39;
    localparam logic [7:0] BRT_ADDR_FIRST   = BRT_ADDR_NORMAL;
    localparam logic [7:0] BRT_ADDR_LAST    = BRT_ADDR_CONFIG;
    localparam int         BRT_NUM_REGS     = 5;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         BRT_SETPT_W      = 6;
    localparam int         BRT_RANGE_BIT    = 6;
    localparam logic [7:0] BRT_SETPT_WMASK  = 8'h3f;
    localparam logic [7:0] BRT_MODE_WMASK   = 8'h2f;
    localparam logic [7:0] BRT_CONFIG_WMASK = 8'hfd;
    localparam logic [7:0] BRT_RESET_VAL    = 8'h00;
    localparam logic [7:0] BRT_ZERO_BYTE    = 8'h00;

    typedef enum logic [1:0] {
        BRT_OP_NORMAL,
        BRT_OP_STANDBY,
        BRT_OP_SLEEP
    } brt_op_state_e;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } brt_req_s;

    typedef struct packed {
        logic [6:0] voltageCode;
        logic       sleepPfm;
        logic [3:0] switchingMode;
        logic       currentLimitLow;
        logic [1:0] frequencySel;
        logic [1:0] phaseSel;
        logic [1:0] slewSpeedSel;
    } brt_ctrl_s;

    function automatic logic [7:0] brt_mask_write(input logic [7:0] oldV,
                                                  input logic [7:0] newV,
                                                  input logic [7:0] mask);
        brt_mask_write = (oldV & ~mask) | (newV & mask);
    endfunction : brt_mask_write
endpackage : brt_pkg

// File: logic/brt_reg_cell.sv
`timescale 1ns/1ps
module brt_reg_cell
    import brt_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hff
) (
    input  wire logic       core_clk, // Logic clock
    input  wire logic       reset,    // Async reset
    input  wire logic       wrEn,     // Write strobe for this register
    input  wire logic [7:0] wrData,   // Host write byte
    output logic      [7:0] value     // Stored writable bits
);
    logic [7:0] value_q;
    logic [7:0] value_d;

    // Bits outside the mask keep reset value, so they read zero
    assign value_d = wrEn ? brt_mask_write(value_q, wrData, WMASK) : value_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            value_q <= BRT_RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule : brt_reg_cell

// File: tb/brt_regbank_properties.sv
`timescale 1ns/1ps
module brt_regbank_properties
    import brt_pkg::*;
(
    input wire logic          core_clk, // Clock
    input wire logic          reset,    // Reset
    input wire brt_req_s      req,      // Request
    input wire logic   [7:0]  rdData,   // Read byte
    input wire logic          rdValid,  // Read valid
    input wire logic          cfgLoad,  // Range load
    input wire logic          cfgRange, // Range value
    input wire brt_op_state_e opState,  // State
    input wire brt_ctrl_s     ctrl      // Controls
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire cfgWr = req.write && req.addr == BRT_ADDR_CONFIG;
    wire offMap = req.addr < BRT_ADDR_FIRST || req.addr > BRT_ADDR_LAST;
    rd_pulse_a: assert property (req.read |=> rdValid) else $error("read not answered");
    rd_quiet_a: assert property (!req.read |=> !rdValid) else $error("stray read valid");
    rd_hold_a: assert property (!req.read |=> $stable(rdData)) else $error("read byte moved");
    off_map_a: assert property (req.read && offMap |=> rdData == 8'h00) else $error("unmapped read");
    mode_unused_a: assert property (req.read && req.addr == BRT_ADDR_MODE |=> (rdData & 8'hd0) == 8'h00)
        else $error("mode unused bits");
    cfg_bit_a: assert property (req.read && req.addr == BRT_ADDR_CONFIG |=> !rdData[1])
        else $error("config bit 1 set");
    range_hold_a: assert property (!cfgLoad [*3] |-> $stable(ctrl.voltageCode[6]))
        else $error("range bit moved");
    cfg_follow_a: assert property (cfgWr ##1 !cfgWr |=> ctrl.slewSpeedSel == $past(req.wdata[7:6], 2)
        && ctrl.currentLimitLow == $past(req.wdata[0], 2)) else $error("config not applied");
endmodule : brt_regbank_properties
bind brt_regbank brt_regbank_properties u_brt_regbank_properties (.core_clk(core_clk), .reset(reset),
    .req(req), .rdData(rdData), .rdValid(rdValid), .cfgLoad(cfgLoad), .cfgRange(cfgRange),
    .opState(opState), .ctrl(ctrl));

// File: tb/brt_host_model.sv
`timescale 1ns/1ps
module brt_host_model
    import brt_pkg::*;
(
    input  wire logic       core_clk, // Clock
    output brt_req_s        req,      // Request
    input  wire logic [7:0] rdData,   // Read byte
    input  wire logic       rdValid   // Read valid
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        req.write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge core_clk);
        req = '{write: 1'b0, read: 1'b1, addr: a, wdata: ~req.wdata};
        @(negedge core_clk);
        req.read = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rdValid === 1'b1) begin
                ok = 1'b1;
                d = rdData;
            end else @(negedge core_clk);
        end
    endtask : rd
endmodule : brt_host_model

// File: tb/brt_regbank_tb.sv
`timescale 1ns/1ps
module brt_regbank_tb
    import brt_pkg::*;
;
    logic core_clk, reset, rdValid, cfgLoad, cfgRange, ok;
    logic [7:0] rdData, d;
    brt_req_s req;
    brt_op_state_e opState;
    brt_ctrl_s ctrl;
    int fail_count, check_count;
    always #12.5 core_clk = ~core_clk;
    brt_regbank u_brt_regbank (.core_clk(core_clk), .reset(reset), .req(req), .rdData(rdData),
        .rdValid(rdValid), .cfgLoad(cfgLoad), .cfgRange(cfgRange), .opState(opState), .ctrl(ctrl));
    brt_host_model u_brt_host_model (.core_clk(core_clk), .req(req), .rdData(rdData), .rdValid(rdValid));
    task automatic wrap_up();
        $display("fail_count %0d check_count %0d", fail_count, check_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_brt_host_model.rd(a, d, ok);
        if (!ok) begin
            fail_count++;
            $display("ERROR rdValid expected 1 seen 0");
            wrap_up();
        end
        chk("readback", {11'h0, e}, {11'h0, d});
    endtask : rdchk
    task automatic write_ones();
        logic [7:0] exp [5] = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hfd};
        for (int i = 0; i < 5; i++) rdchk(8'h35 + i[7:0], 8'h00);
        for (int i = 0; i < 5; i++) begin
            u_brt_host_model.wr(8'h35 + i[7:0], 8'hff);
            rdchk(8'h35 + i[7:0], exp[i]);
        end
        repeat (3) @(negedge core_clk);
        chk("ctrl", {7'h3f, 1'b1, 4'hf, 1'b1, 2'h3, 2'h3, 2'h3}, ctrl);
        u_brt_host_model.wr(BRT_ADDR_CONFIG, 8'h41);
        repeat (3) @(negedge core_clk);
        chk("ctrl", {7'h3f, 1'b1, 4'hf, 1'b1, 2'h0, 2'h0, 2'h1}, ctrl);
    endtask : write_ones
    task automatic range_and_state();
        logic [6:0] vc [3] = '{7'h40, 7'h62, 7'h73};
        u_brt_host_model.wr(8'h35, 8'h80);
        u_brt_host_model.wr(8'h36, 8'h22);
        u_brt_host_model.wr(8'h37, 8'h33);
        @(negedge core_clk);
        cfgLoad = 1'b1;
        cfgRange = 1'b1;
        @(negedge core_clk);
        cfgLoad = 1'b0;
        rdchk(8'h35, 8'h40);
        rdchk(8'h36, 8'h62);
        rdchk(8'h37, 8'h73);
        for (int i = 0; i < 3; i++) begin
            opState = brt_op_state_e'(i);
            repeat (3) @(negedge core_clk);
            chk("voltageCode", {12'h0, vc[i]}, {12'h0, ctrl.voltageCode});
        end
    endtask : range_and_state
    task automatic off_map();
        u_brt_host_model.wr(8'h34, 8'hff);
        u_brt_host_model.wr(8'h3a, 8'hff);
        rdchk(8'h34, 8'h00);
        rdchk(8'h3a, 8'h00);
        rdchk(8'h35, 8'h40);
    endtask : off_map
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        cfgLoad = 1'b0;
        cfgRange = 1'b0;
        opState = BRT_OP_NORMAL;
        fail_count = 0;
        check_count = 0;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        write_ones();
        range_and_state();
        off_map();
        wrap_up();
    end
endmodule : brt_regbank_tb
